// ===== hdrx_device.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`include "hdrx_regs.svh"
// Behaviour
// - Mode 101 matches high address byte only.
// - Mode 101 stores frame minus first byte.
// - Mode 100 stores all; capture bytes one, two.
// - Bad CRC or aborted frames still stored.
// - Mode 110 raw bits, byte into capture.
// - Mode 111 also pushes raw bytes.
// - Poll and acknowledge frames handled internally in modes 000 to 100.
// - Extended transparent repeats transmit fifo cyclically.
// - Repeat clear stops after cycle; reset immediately.
// - Continuous send requests per 32 free bytes.
// - Cleared continuous send honours twelve-bit count.
// - Underrun sends seven-plus ones abort, no CRC.
// - Maximum length is (field+1) times 32.
// - Overlong frame ends as abort, flags set.
// - One clock; mode 1 strobe gates transfer.
// - Mode 2 transfers only inside slot.
// - Slot start is slot*8 plus shift.
// - Slot active for programmed width plus one bits.
// - Mode 3 shares channel, transparent 0 only.
// - Mode 3 monitors transmit data one bit late.
// - Mode 3 status byte: valid, overflow, crc, channel.
// - Invalid on odd bits, short, aborted.
// - Fifo overflow recorded in status byte.
module hdrx_device #(
	parameter int FIFO_DEPTH = 64,
	parameter int ADDR_W = 6
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	hdrx_link_if.device link,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic dma_req_out,
	output logic message_end_irq_out
);
	// Pin synchronisers: three stages, a change counts when stages 2 and 3 agree.
	logic [2:0] clk_s_ff, stb_s_ff, fs_s_ff, din_s_ff;
	logic clk_q_ff, stb_q_ff, fs_q_ff, din_q_ff;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_s_ff <= 3'h0;
			stb_s_ff <= 3'h0;
			fs_s_ff <= 3'h0;
			din_s_ff <= 3'h7;
			clk_q_ff <= 1'b0;
			stb_q_ff <= 1'b0;
			fs_q_ff <= 1'b0;
			din_q_ff <= 1'b1;
		end else begin
			clk_s_ff <= {clk_s_ff[1:0], link.serial_clock_pin};
			stb_s_ff <= {stb_s_ff[1:0], link.strobe_sync_pin};
			fs_s_ff <= {fs_s_ff[1:0], link.frame_sync_pin};
			din_s_ff <= {din_s_ff[1:0], link.serial_in_pin};
			if (clk_s_ff[1] == clk_s_ff[2]) clk_q_ff <= clk_s_ff[2];
			if (stb_s_ff[1] == stb_s_ff[2]) stb_q_ff <= stb_s_ff[2];
			if (fs_s_ff[1] == fs_s_ff[2]) fs_q_ff <= fs_s_ff[2];
			if (din_s_ff[1] == din_s_ff[2]) din_q_ff <= din_s_ff[2];
		end
	end
	wire clk_now = (clk_s_ff[1] == clk_s_ff[2]) ? clk_s_ff[2] : clk_q_ff;
	wire fs_now = (fs_s_ff[1] == fs_s_ff[2]) ? fs_s_ff[2] : fs_q_ff;
	wire bit_rise = clk_now && !clk_q_ff;
	wire bit_fall = !clk_now && clk_q_ff;
	wire fs_rise = fs_now && !fs_q_ff;

	// Registers.
	logic [2:0] mode_ff;
	logic [1:0] clk_mode_ff;
	logic repeat_transmit_bit_ff, continuous_send_bit_ff, continuous_fill_bit_ff;
	logic length_check_enable_ff, monitor_out_enable_ff;
	logic [6:0] max_length_field_ff;
	logic [7:0] high_addr_match_1_ff, high_addr_match_2_ff;
	logic [4:0] channel_id_field_ff;
	logic [5:0] rx_slot_ff, tx_slot_ff;
	logic [2:0] rx_shift_ff, tx_shift_ff;
	logic [7:0] rx_slot_width_ff, tx_slot_width_ff;
	logic [11:0] tx_count_ff;
	logic [7:0] low_addr_capture_ff, ctrl_field_capture_ff, receive_status_ff;
	logic [11:0] rx_count_ff;
	logic wb_ack_ff;
	logic [31:0] wb_dat_ff;
	// Transmit and receive fifos.
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [ADDR_W:0] tx_wp_ff, tx_rp_ff, tx_base_ff, rx_wp_ff, rx_rp_ff;
	wire [ADDR_W:0] tx_used = tx_wp_ff - tx_rp_ff;
	wire [ADDR_W:0] rx_used = rx_wp_ff - rx_rp_ff;
	wire rx_full = rx_used[ADDR_W];
	wire tx_empty = (tx_used == '0);

	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
	wire [3:0] wb_reg = wb_adr_i[5:2];
	wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	wire wr_ctrl = wb_wr && wb_reg == `HDRX_REG_CTRL;
	wire wr_txd = wb_wr && wb_reg == `HDRX_REG_TXDATA && !tx_used[ADDR_W];
	wire rd_rxd = wb_req && !wb_we_i && wb_reg == `HDRX_REG_RXDATA && rx_used != '0;
	wire is_ext = mode_ff[1] && mode_ff[2];
	wire cmd_transmit_reset_cmd = wr_ctrl && wb_dat_i[31];
	wire cmd_start = wr_ctrl && wb_dat_i[30]; // transparent_send_cmd with message_end_cmd

	// Slot window for mode 2, gating for modes 1 and 3.
	logic [9:0] bit_pos_ff;
	logic [2:0] mon_pos_ff;
	wire [9:0] rx_start = {1'b0, rx_slot_ff, rx_shift_ff} + 10'h001;
	wire [9:0] tx_start = {1'b0, tx_slot_ff, tx_shift_ff} + 10'h001;
	wire rx_in_slot = bit_pos_ff >= rx_start && bit_pos_ff <= rx_start + {2'b00, rx_slot_width_ff};
	wire tx_in_slot = bit_pos_ff >= tx_start && bit_pos_ff <= tx_start + {2'b00, tx_slot_width_ff};
	wire mon_stb = mon_pos_ff >= `HDRX_MON_FIRST && mon_pos_ff <= `HDRX_MON_LAST;
	logic rx_gate, tx_gate;
	always_comb begin
		unique case (clk_mode_ff)
			2'd0: begin rx_gate = 1'b1; tx_gate = 1'b1; end
			2'd1: begin rx_gate = stb_q_ff; tx_gate = stb_q_ff; end
			2'd2: begin rx_gate = rx_in_slot; tx_gate = tx_in_slot; end
			2'd3: begin rx_gate = stb_q_ff; tx_gate = stb_q_ff || mon_stb; end
		endcase
	end
	wire rx_bit = bit_fall && rx_gate;
	wire tx_bit = bit_rise && tx_gate;

	// Receive side.
	logic [7:0] rx_sh_ff;
	logic [2:0] rx_nbit_ff;
	logic [2:0] ones_ff;
	logic in_frame_ff, addr_ok_ff, ovf_ff, skip_ff;
	logic [15:0] crc_ff;
	wire [7:0] byte_now = {din_q_ff, rx_sh_ff[7:1]};
	wire byte_done = rx_bit && rx_nbit_ff == 3'h7;
	// One bit wider than the byte count so that the largest limit of 4096 does not wrap.
	wire [12:0] max_len = {6'h00, max_length_field_ff} + 13'h0001;
	wire too_long = length_check_enable_ff &&
		{1'b0, rx_count_ff} > (max_len << `HDRX_LEN_BLOCK_SHIFT);
	wire addr_hit = byte_now == high_addr_match_1_ff || byte_now == high_addr_match_2_ff ||
		byte_now == `HDRX_GROUP_ADDR_A || byte_now == `HDRX_GROUP_ADDR_B;
	wire is_poll = (ctrl_field_capture_ff & `HDRX_CTRL_RR_MASK) == `HDRX_CTRL_RR ||
		byte_now[7:4] == `HDRX_CMD_PREPARED_HI ||
		(byte_now >= `HDRX_ACK_LO && byte_now <= `HDRX_ACK_HI);
	wire flag_seen = rx_bit && byte_now == `HDRX_FLAG;
	wire abort_seen = rx_bit && din_q_ff && ones_ff == 3'h6;
	wire frame_end = in_frame_ff && (flag_seen || abort_seen || too_long);
	wire crc_ok = crc_ff == 16'h0000;
	// A whole frame ends with its closing flag on the eighth bit of a byte.
	wire bad_len = rx_nbit_ff != 3'h7 || abort_seen || too_long ||
		(mode_ff == `HDRX_MODE_TRANSP0 && rx_count_ff < `HDRX_MIN_TRANSP0_BYTES);
	wire [7:0] status_std = {!bad_len, ovf_ff, crc_ok, abort_seen || too_long, 4'h0};
	wire [7:0] status_m3 = {!bad_len, ovf_ff, crc_ok, channel_id_field_ff};
	wire store_byte = in_frame_ff && byte_done && addr_ok_ff && !skip_ff &&
		!(mode_ff == `HDRX_MODE_TRANSP1 && rx_count_ff == 12'h000);
	wire ext_push = is_ext && mode_ff[0] && byte_done;
	wire push = store_byte || ext_push || (frame_end && addr_ok_ff && !skip_ff);
	wire [7:0] push_data = frame_end ? (clk_mode_ff == 2'd3 ? status_m3 : status_std) :
		byte_now;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_sh_ff <= 8'h00;
			rx_nbit_ff <= 3'h0;
			ones_ff <= 3'h0;
			in_frame_ff <= 1'b0;
			addr_ok_ff <= 1'b0;
			ovf_ff <= 1'b0;
			skip_ff <= 1'b0;
			crc_ff <= 16'hffff;
			rx_count_ff <= 12'h000;
			low_addr_capture_ff <= 8'h00;
			ctrl_field_capture_ff <= 8'h00;
			receive_status_ff <= 8'h00;
			rx_wp_ff <= '0;
			message_end_irq_out <= 1'b0;
		end else begin
			message_end_irq_out <= 1'b0;
			if (rx_bit) begin
				rx_sh_ff <= byte_now;
				rx_nbit_ff <= rx_nbit_ff + 3'h1;
				ones_ff <= din_q_ff ? (ones_ff == 3'h7 ? ones_ff : ones_ff + 3'h1) : 3'h0;
				crc_ff <= {crc_ff[14:0], 1'b0} ^ ((crc_ff[15] ^ din_q_ff) ? 16'h1021 : 16'h0);
			end
			if (is_ext) begin
				if (byte_done) low_addr_capture_ff <= byte_now;
			end else if (flag_seen) begin
				in_frame_ff <= 1'b1;
				rx_nbit_ff <= 3'h0;
				rx_count_ff <= 12'h000;
				ovf_ff <= 1'b0;
				skip_ff <= 1'b0;
				addr_ok_ff <= (mode_ff != `HDRX_MODE_TRANSP1);
				crc_ff <= 16'hffff;
			end else if (in_frame_ff && byte_done) begin
				rx_count_ff <= rx_count_ff + 12'h001;
				if (rx_count_ff == 12'h000) begin
					if (mode_ff == `HDRX_MODE_TRANSP1) addr_ok_ff <= addr_hit;
					else low_addr_capture_ff <= byte_now;
				end
				if (rx_count_ff == 12'h001) begin
					if (mode_ff == `HDRX_MODE_TRANSP1) low_addr_capture_ff <= byte_now;
					else ctrl_field_capture_ff <= byte_now;
				end
				if (rx_count_ff == 12'h002) begin
					if (mode_ff == `HDRX_MODE_TRANSP1) ctrl_field_capture_ff <= byte_now;
					else if (is_poll) skip_ff <= 1'b1;
				end
			end
			if (frame_end) begin
				in_frame_ff <= 1'b0;
				if (clk_mode_ff != 2'd3) receive_status_ff <= status_std;
				message_end_irq_out <= addr_ok_ff && !skip_ff;
			end
			if (push && rx_full) ovf_ff <= 1'b1;
			if (push && !rx_full) begin
				rx_mem[rx_wp_ff[ADDR_W-1:0]] <= push_data;
				rx_wp_ff <= rx_wp_ff + 1'b1;
			end
		end
	end

	// Transmit side.
	hdrx_pkg::hdrx_tx_state_t tx_state_ff;
	logic [7:0] tx_sh_ff;
	logic [2:0] tx_nbit_ff;
	logic [3:0] abort_cnt_ff;
	logic [11:0] tx_left_ff;
	logic serial_out_ff, mon_ff, dma_ff;
	wire tx_byte_edge = tx_bit && tx_nbit_ff == 3'h7;
	wire wrap = tx_used == 7'(1) && repeat_transmit_bit_ff;
	wire mon_on = monitor_out_enable_ff && clk_mode_ff == 2'd3;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_state_ff <= hdrx_pkg::HDRX_TX_IDLE;
			tx_sh_ff <= 8'hff;
			tx_nbit_ff <= 3'h0;
			abort_cnt_ff <= 4'h0;
			tx_rp_ff <= '0;
			tx_base_ff <= '0;
			serial_out_ff <= 1'b1;
			mon_ff <= 1'b1;
			dma_ff <= 1'b0;
			tx_left_ff <= 12'h000;
		end else begin
			dma_ff <= continuous_send_bit_ff ? (7'(FIFO_DEPTH) - tx_used >= `HDRX_FIFO_BLOCK)
				: (tx_left_ff != 12'h000 && !tx_used[ADDR_W]);
			if (wr_txd && tx_left_ff != 12'h000 && !continuous_send_bit_ff) tx_left_ff <= tx_left_ff - 12'h001;
			if (wb_wr && wb_reg == `HDRX_REG_TXCNT) tx_left_ff <= wb_dat_i[11:0];
			if (tx_bit) begin
				serial_out_ff <= tx_sh_ff[0];
				mon_ff <= serial_out_ff;
				tx_nbit_ff <= tx_nbit_ff + 3'h1;
				tx_sh_ff <= {1'b1, tx_sh_ff[7:1]};
			end
			if (!mon_on) mon_ff <= 1'b1;
			if (cmd_transmit_reset_cmd) begin
				tx_state_ff <= hdrx_pkg::HDRX_TX_IDLE;
				tx_rp_ff <= tx_wp_ff;
				tx_sh_ff <= `HDRX_FLAG;
			end else begin
				unique case (tx_state_ff)
					hdrx_pkg::HDRX_TX_IDLE: begin
						if (tx_byte_edge) tx_sh_ff <= is_ext ? 8'hff : `HDRX_FLAG;
						if (cmd_start && !continuous_fill_bit_ff) begin
							tx_state_ff <= hdrx_pkg::HDRX_TX_DATA;
							tx_base_ff <= tx_rp_ff;
						end
					end
					hdrx_pkg::HDRX_TX_DATA: begin
						if (tx_byte_edge) begin
							if (tx_empty) begin
								tx_state_ff <= hdrx_pkg::HDRX_TX_ABORT;
								tx_sh_ff <= 8'hff;
								abort_cnt_ff <= 4'h0;
							end else begin
								tx_sh_ff <= tx_mem[tx_rp_ff[ADDR_W-1:0]];
								tx_rp_ff <= wrap ? tx_base_ff : tx_rp_ff + 1'b1;
								if (tx_used == 7'(1) && !repeat_transmit_bit_ff && !continuous_send_bit_ff)
									tx_state_ff <= hdrx_pkg::HDRX_TX_IDLE;
							end
						end
					end
					hdrx_pkg::HDRX_TX_ABORT: begin
						if (tx_bit) abort_cnt_ff <= abort_cnt_ff + 4'h1;
						if (tx_byte_edge && abort_cnt_ff >= {1'b0, `HDRX_ABORT_ONES}) begin
							tx_state_ff <= hdrx_pkg::HDRX_TX_IDLE;
							tx_sh_ff <= `HDRX_FLAG;
						end
					end
				endcase
			end
		end
	end
	assign link.serial_out_pin = serial_out_ff;
	assign link.serial_out_oe = 1'b1;
	assign link.monitor_pin_a = mon_ff;
	assign dma_req_out = dma_ff;

	// Slot position counters.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bit_pos_ff <= 10'h000;
			mon_pos_ff <= 3'h0;
		end else if (fs_rise) begin
			bit_pos_ff <= 10'h000;
			mon_pos_ff <= 3'h0;
		end else if (bit_rise) begin
			if (bit_pos_ff != 10'h3ff) bit_pos_ff <= bit_pos_ff + 10'h001;
			if (mon_pos_ff != 3'h7) mon_pos_ff <= mon_pos_ff + 3'h1;
		end
	end

	// Wishbone slave: answers one cycle after the request, no wait states.
	logic [31:0] rd_mux;
	always_comb begin
		unique case (wb_reg)
			`HDRX_REG_CTRL: rd_mux = {9'h000, max_length_field_ff, monitor_out_enable_ff,
				length_check_enable_ff, continuous_fill_bit_ff, continuous_send_bit_ff,
				repeat_transmit_bit_ff, clk_mode_ff, mode_ff, 6'h00};
			`HDRX_REG_ADDR: rd_mux = {11'h0, channel_id_field_ff, high_addr_match_2_ff, high_addr_match_1_ff};
			`HDRX_REG_SLOT: rd_mux = {rx_slot_width_ff, tx_slot_width_ff, rx_slot_ff, rx_shift_ff[2:1], tx_slot_ff, tx_shift_ff[2:1]};
			`HDRX_REG_TXCNT: rd_mux = {20'h0, tx_left_ff};
			`HDRX_REG_RXDATA: rd_mux = {24'h0, rx_mem[rx_rp_ff[ADDR_W-1:0]]};
			`HDRX_REG_CAPT: rd_mux = {8'h0, receive_status_ff, ctrl_field_capture_ff, low_addr_capture_ff};
			`HDRX_REG_STATUS: rd_mux = {14'h0, rx_count_ff, tx_state_ff, 1'b0, rx_full, tx_empty};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0;
			rx_rp_ff <= '0;
			tx_wp_ff <= '0;
			mode_ff <= 3'h0;
			clk_mode_ff <= 2'd0;
			{monitor_out_enable_ff, length_check_enable_ff, continuous_fill_bit_ff} <= 3'h0;
			{continuous_send_bit_ff, repeat_transmit_bit_ff} <= 2'h0;
			max_length_field_ff <= 7'h00;
			{high_addr_match_1_ff, high_addr_match_2_ff, channel_id_field_ff} <= 21'h0;
			{rx_slot_ff, rx_shift_ff, tx_slot_ff, tx_shift_ff} <= 18'h0;
			{rx_slot_width_ff, tx_slot_width_ff} <= 16'h0;
		end else begin
			wb_ack_ff <= wb_req;
			wb_dat_ff <= wb_req && !wb_we_i ? rd_mux : 32'h0;
			if (rd_rxd) rx_rp_ff <= rx_rp_ff + 1'b1;
			if (wr_txd) begin
				tx_mem[tx_wp_ff[ADDR_W-1:0]] <= wb_dat_i[7:0];
				tx_wp_ff <= tx_wp_ff + 1'b1;
			end
			if (wr_ctrl) begin
				{monitor_out_enable_ff, length_check_enable_ff, continuous_fill_bit_ff} <= wb_dat_i[15:13];
				{continuous_send_bit_ff, repeat_transmit_bit_ff} <= wb_dat_i[12:11];
				clk_mode_ff <= wb_dat_i[10:9];
				mode_ff <= wb_dat_i[8:6];
				max_length_field_ff <= wb_dat_i[22:16];
			end
			if (wb_wr && wb_reg == `HDRX_REG_ADDR) begin
				{channel_id_field_ff, high_addr_match_2_ff, high_addr_match_1_ff} <= wb_dat_i[20:0];
			end
			if (wb_wr && wb_reg == `HDRX_REG_SLOT) begin
				{rx_slot_width_ff, tx_slot_width_ff} <= wb_dat_i[31:16];
				{rx_slot_ff, rx_shift_ff, tx_slot_ff, tx_shift_ff} <= {wb_dat_i[15:10], wb_dat_i[9:8], 1'b0,
					wb_dat_i[7:2], wb_dat_i[1:0], 1'b0};
			end
		end
	end
	assign wb_ack_o = wb_ack_ff;
	assign wb_dat_o = wb_dat_ff;
endmodule

// ===== hdrx_regs.svh
`ifndef HDRX_REGS_SVH
`define HDRX_REGS_SVH
// Mode codes {op_mode_hi, op_mode_lo, addr_mode_bit}.
`define HDRX_MODE_TRANSP1 3'h5
`define HDRX_MODE_TRANSP0 3'h4
`define HDRX_MODE_EXT0 3'h6
`define HDRX_MODE_EXT1 3'h7
// Fixed group addresses.
`define HDRX_GROUP_ADDR_A 8'hfc
`define HDRX_GROUP_ADDR_B 8'hfe
// Poll handling codes.
`define HDRX_CMD_PREPARED_HI 4'ha
`define HDRX_ACK_LO 8'hd0
`define HDRX_ACK_HI 8'hef
`define HDRX_CTRL_RR_MASK 8'h0f
`define HDRX_CTRL_RR 8'h01
// HDLC flag, abort length and block sizes.
`define HDRX_FLAG 8'h7e
`define HDRX_ABORT_ONES 4'h7
`define HDRX_FIFO_BLOCK 7'h20
`define HDRX_LEN_BLOCK_SHIFT 5
`define HDRX_MIN_TRANSP0_BYTES 12'h002
// Status byte field positions.
`define HDRX_ST_VALID 7
`define HDRX_ST_OVF 6
`define HDRX_ST_CRC 5
`define HDRX_ST_ABORT 4
// Monitor strobe: fourth and fifth bit after the frame sync edge.
`define HDRX_MON_FIRST 3'h3
`define HDRX_MON_LAST 3'h4
// Wishbone register word addresses (byte address / 4).
`define HDRX_REG_CTRL 4'h0
`define HDRX_REG_ADDR 4'h1
`define HDRX_REG_SLOT 4'h2
`define HDRX_REG_TXCNT 4'h3
`define HDRX_REG_TXDATA 4'h4
`define HDRX_REG_RXDATA 4'h5
`define HDRX_REG_CAPT 4'h6
`define HDRX_REG_STATUS 4'h7
`endif

// ===== hdrx_pkg.sv
package hdrx_pkg;
	typedef enum logic [1:0] {
		hdrx_rx_hunt_t_unused
	} hdrx_dummy_t;
	typedef enum logic [2:0] {
		HDRX_RX_HUNT,
		HDRX_RX_DATA,
		HDRX_RX_RAW
	} hdrx_rx_state_t;
	typedef enum logic [2:0] {
		HDRX_TX_IDLE,
		HDRX_TX_DATA,
		HDRX_TX_ABORT
	} hdrx_tx_state_t;
endpackage

// ===== hdrx_link_if.sv
`timescale 1ns/1ns
interface hdrx_link_if;
	logic serial_clock_pin;
	logic strobe_sync_pin;
	logic frame_sync_pin;
	logic serial_in_pin;
	logic serial_out_pin;
	logic serial_out_oe;
	logic monitor_pin_a;
	modport device (
		input serial_clock_pin,
		input strobe_sync_pin,
		input frame_sync_pin,
		input serial_in_pin,
		output serial_out_pin,
		output serial_out_oe,
		output monitor_pin_a
	);
	modport station (
		output serial_clock_pin,
		output strobe_sync_pin,
		output frame_sync_pin,
		output serial_in_pin,
		input serial_out_pin,
		input serial_out_oe,
		input monitor_pin_a
	);
endinterface

// ===== hdrx_station.sv
`timescale 1ns/1ns
`include "hdrx_regs.svh"
// Far end: makes the bit clock by dividing mclk_in, a frame sync every
// frame_bits clocks, and shifts user bytes out while sampling the return line.
module hdrx_station #(
	parameter int CLK_DIV = 12,
	parameter int FRAME_BITS = 64
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	hdrx_link_if.station link,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	input wire logic strobe_in,
	output logic tx_ready_out,
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out
);
	logic [7:0] div_ff;
	logic sclk_ff;
	logic [8:0] bit_cnt_ff;
	logic [7:0] tx_sh_ff;
	logic [2:0] tx_n_ff;
	logic [7:0] rx_sh_ff;
	logic [2:0] rx_n_ff;
	logic fs_ff;
	logic tx_ready_ff;
	logic [7:0] rx_byte_ff;
	logic rx_valid_ff;
	wire div_end = (div_ff == 8'(CLK_DIV / 2 - 1));
	wire fall = div_end && sclk_ff;
	wire rise = div_end && !sclk_ff;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_ff <= 8'h00;
			sclk_ff <= 1'b0;
			bit_cnt_ff <= 9'h000;
			tx_sh_ff <= 8'hff;
			tx_n_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_n_ff <= 3'h0;
			fs_ff <= 1'b0;
			tx_ready_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
		end else begin
			div_ff <= div_end ? 8'h00 : div_ff + 8'h01;
			tx_ready_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			if (div_end) begin
				sclk_ff <= !sclk_ff;
			end
			if (fall) begin
				bit_cnt_ff <= (bit_cnt_ff == 9'(FRAME_BITS - 1)) ? 9'h000 : bit_cnt_ff + 9'h001;
				fs_ff <= (bit_cnt_ff == 9'(FRAME_BITS - 1));
				if (tx_n_ff == 3'h7) begin
					tx_sh_ff <= tx_valid_in ? tx_byte_in : 8'hff;
					tx_ready_ff <= 1'b1;
				end else begin
					tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
				end
				tx_n_ff <= tx_n_ff + 3'h1;
			end
			if (rise && link.serial_out_oe) begin
				rx_sh_ff <= {rx_sh_ff[6:0], link.serial_out_pin};
				rx_n_ff <= rx_n_ff + 3'h1;
				if (rx_n_ff == 3'h7) begin
					rx_byte_ff <= {rx_sh_ff[6:0], link.serial_out_pin};
					rx_valid_ff <= 1'b1;
				end
			end
		end
	end
	assign link.serial_clock_pin = sclk_ff;
	assign link.serial_in_pin = tx_sh_ff[7];
	assign link.strobe_sync_pin = strobe_in | fs_ff;
	assign link.frame_sync_pin = fs_ff;
	assign tx_ready_out = tx_ready_ff;
	assign rx_byte_out = rx_byte_ff;
	assign rx_valid_out = rx_valid_ff;
endmodule

// ===== hdrx_checker.sv
`timescale 1ns/1ns
module hdrx_checker (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic serial_clock_pin,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe,
	input wire logic monitor_pin_a,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic dma_req_out,
	input wire logic message_end_irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	logic clk_prev_ff;
	logic [3:0] rise_age_ff;
	// Cycles since the raw bit clock last rose; line outputs may only move shortly after.
	wire clk_rise = serial_clock_pin && !clk_prev_ff;
	wire [3:0] nxt_rise_age = clk_rise ? 4'h0 : (rise_age_ff == 4'hf) ? 4'hf : rise_age_ff + 4'h1;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_prev_ff <= 1'b0;
			rise_age_ff <= 4'hf;
		end else begin
			clk_prev_ff <= serial_clock_pin;
			rise_age_ff <= nxt_rise_age;
		end
	end
	sequence wb_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	a_tx_after_rise: assert property ($changed(serial_out_pin) |-> rise_age_ff < 4'ha)
		else $error("serial output moved away from a bit clock rise");
	a_monitor_after_rise: assert property ($changed(monitor_pin_a) |-> rise_age_ff < 4'ha)
		else $error("monitor output moved away from a bit clock rise");
	a_oe_driven: assert property (serial_out_oe)
		else $error("serial output not driven");
	a_idle_at_reset: assert property ($rose(reset_n_in) |-> serial_out_pin && monitor_pin_a && !dma_req_out)
		else $error("line not idle after reset");
	a_ack_follows_req: assert property (wb_request |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_irq_pulse: assert property (message_end_irq_out |=> !message_end_irq_out)
		else $error("frame end event longer than one cycle");
endmodule

// ===== hdrx_rx_modes_serial_port_tb_top.sv
`timescale 1ns/1ns
`include "hdrx_regs.svh"
module hdrx_rx_modes_serial_port_tb_top;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [5:0] wb_adr = 6'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic dma_req;
	logic me_irq;
	logic [7:0] st_byte = 8'h00;
	logic st_valid = 1'b0;
	logic st_ready;
	logic [7:0] st_rx;
	logic st_rx_valid;
	int error_cnt = 0;
	int num_checks = 0;
	int irq_cnt = 0;
	int cycles = 0;
	hdrx_link_if link ();
	hdrx_device hdrx_device_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.dma_req_out(dma_req), .message_end_irq_out(me_irq));
	hdrx_station hdrx_station_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link),
		.tx_byte_in(st_byte), .tx_valid_in(st_valid), .strobe_in(1'b0), .tx_ready_out(st_ready),
		.rx_byte_out(st_rx), .rx_valid_out(st_rx_valid));
	hdrx_checker hdrx_checker_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.serial_clock_pin(link.serial_clock_pin), .serial_out_pin(link.serial_out_pin),
		.serial_out_oe(link.serial_out_oe), .monitor_pin_a(link.monitor_pin_a),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .dma_req_out(dma_req),
		.message_end_irq_out(me_irq));
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (me_irq === 1'b1) begin
			irq_cnt++;
		end
		if (cycles == 90000) begin
			error_cnt++;
			$display("Error at %0t: run timed out", $time);
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [3:0] word, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {word, 2'b00};
		wb_wdat <= wd;
		do @(posedge mclk_in); while (wb_ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge mclk_in);
		st_byte <= b;
		st_valid <= 1'b1;
		do @(posedge mclk_in); while (st_ready !== 1'b1);
		st_valid <= 1'b0;
	endtask
	// Bytes are bit palindromes without five ones in a row: no stuffing, order-proof.
	task automatic frame(input logic [7:0] q[5]);
		send(`HDRX_FLAG);
		foreach (q[i]) send(q[i]);
		send(`HDRX_FLAG);
	endtask
	task automatic wait_irq(output logic got);
		int c0;
		c0 = irq_cnt;
		for (int n = 0; n < 3000 && irq_cnt == c0; n++) @(posedge mclk_in);
		got = (irq_cnt != c0);
	endtask
	task automatic rx_byte(output logic [7:0] b);
		do @(posedge mclk_in); while (st_rx_valid !== 1'b1);
		b = st_rx;
	endtask
	task automatic t_unmapped();
		logic [31:0] d;
		bus(1'b0, 4'h8, 32'h0, d);
		check(d, 32'h0);
		bus(1'b0, 4'hf, 32'h0, d);
		check(d, 32'h0);
		$display("test unmapped done");
	endtask
	task automatic t_transp0();
		logic [31:0] d;
		logic got;
		bus(1'b1, `HDRX_REG_CTRL, {23'h0, `HDRX_MODE_TRANSP0, 6'h00}, d);
		frame('{8'h3c, 8'h18, 8'h66, 8'h24, 8'h5a});
		wait_irq(got);
		check(got, 1'b1);
		bus(1'b0, `HDRX_REG_CAPT, 32'h0, d);
		check(d[15:0], 16'h183c);
		check(d[16+`HDRX_ST_CRC], 1'b0);
		check(d[16+`HDRX_ST_VALID], 1'b1);
		bus(1'b0, `HDRX_REG_RXDATA, 32'h0, d);
		check(d[7:0], 8'h3c);
		bus(1'b0, `HDRX_REG_RXDATA, 32'h0, d);
		check(d[7:0], 8'h18);
		$display("test transparent 0 done");
	endtask
	task automatic t_length();
		logic [31:0] d;
		int c0;
		c0 = irq_cnt;
		bus(1'b1, `HDRX_REG_CTRL, {17'h0, 1'b1, 5'h00, `HDRX_MODE_TRANSP0, 6'h00}, d);
		send(`HDRX_FLAG);
		repeat (34) send(8'h18);
		repeat (300) @(posedge mclk_in);
		check(irq_cnt - c0, 1);
		bus(1'b0, `HDRX_REG_CAPT, 32'h0, d);
		check(d[16+`HDRX_ST_ABORT], 1'b1);
		check(d[16+`HDRX_ST_VALID], 1'b0);
		bus(1'b0, `HDRX_REG_STATUS, 32'h0, d);
		check(d[17:6] == 12'h021 || d[17:6] == 12'h022, 1'b1);
		$display("test length check done");
	endtask
	task automatic t_transp1();
		logic [31:0] d;
		logic got;
		bus(1'b1, `HDRX_REG_CTRL, {23'h0, `HDRX_MODE_TRANSP1, 6'h00}, d);
		bus(1'b1, `HDRX_REG_ADDR, 32'h3c3c, d);
		frame('{8'h24, 8'h18, 8'h66, 8'h24, 8'h5a});
		wait_irq(got);
		check(got, 1'b0);
		frame('{8'h3c, 8'h18, 8'h66, 8'h24, 8'h5a});
		wait_irq(got);
		check(got, 1'b1);
		bus(1'b0, `HDRX_REG_CAPT, 32'h0, d);
		check(d[15:0], 16'h6618);
		$display("test transparent 1 done");
	endtask
	task automatic t_ext_tx();
		logic [31:0] d;
		logic [7:0] b;
		bus(1'b1, `HDRX_REG_CTRL, {20'h0, 1'b1, 2'b00, `HDRX_MODE_EXT0, 6'h00}, d);
		for (int i = 0; i < 32; i++) bus(1'b1, `HDRX_REG_TXDATA, 32'h55, d);
		bus(1'b1, `HDRX_REG_CTRL, {19'h0, 2'b11, 2'b00, `HDRX_MODE_EXT0, 6'h00}, d);
		check(dma_req, 1'b1);
		bus(1'b1, `HDRX_REG_CTRL, {2'b01, 18'h0, 1'b1, 2'b00, `HDRX_MODE_EXT0, 6'h00}, d);
		check(dma_req, 1'b0);
		repeat (34) rx_byte(b);
		for (int i = 0; i < 4; i++) begin
			rx_byte(b);
			check(b === 8'h55 || b === 8'haa, 1'b1);
		end
		bus(1'b1, `HDRX_REG_CTRL, {23'h0, `HDRX_MODE_EXT0, 6'h00}, d);
		repeat (40) rx_byte(b);
		rx_byte(b);
		check(b, 8'hff);
		for (int i = 0; i < 4; i++) bus(1'b1, `HDRX_REG_TXDATA, 32'h55, d);
		bus(1'b1, `HDRX_REG_CTRL, {2'b01, 18'h0, 1'b1, 2'b00, `HDRX_MODE_EXT0, 6'h00}, d);
		repeat (4) rx_byte(b);
		bus(1'b1, `HDRX_REG_CTRL, {2'b10, 18'h0, 1'b1, 2'b00, `HDRX_MODE_EXT0, 6'h00}, d);
		repeat (2) rx_byte(b);
		rx_byte(b);
		check(b, 8'hff);
		$display("test cyclic transmit done");
	endtask
	task automatic t_ext_rx();
		logic [31:0] d;
		bus(1'b1, `HDRX_REG_CTRL, {23'h0, `HDRX_MODE_EXT1, 6'h00}, d);
		repeat (6) send(8'h00);
		bus(1'b0, `HDRX_REG_CAPT, 32'h0, d);
		check(d[7:0], 8'h00);
		$display("test raw receive done");
	endtask
	initial begin
		repeat (5) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(posedge mclk_in);
		t_unmapped();
		t_transp0();
		t_length();
		t_transp1();
		t_ext_tx();
		t_ext_rx();
		conclude();
	end
endmodule
